// >>> hdl/dadc_port.sv
// Dual converter output port: channel pipelines, capture FIFO and Avalon-MM control.
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Swap select high puts channel A on bus A and channel B on bus B.
// - Swap select low crosses the buses: A on bus B, B on bus A.
// - Power select low converts; bus driven when drive enable low, else high impedance.
// - Power select high gives nap with enable low, sleep with enable high; buses float.
// - One mode code sets format and stabilizer for both channels.
// - Each channel result is a 12-bit word with the top bit as MSB.
// - A channel takes its sample on the rising edge of its own clock.
// - The data ready strobe follows the channel B clock only.
// - Out-of-range flag is high when either channel result overflowed or underflowed.
// - A result appears on the bus five clock cycles after its sample.

module dadc_fifo #(
   parameter int WIDTH = 25,
   parameter int DEPTH = 8
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_i,
   input  wire logic                       in_valid_i,
   output logic                            in_ready_o,
   input  wire logic [WIDTH-1:0]           in_data_i,
   output logic                            out_valid_o,
   input  wire logic                       out_ready_i,
   output logic [WIDTH-1:0]                out_data_o,
   output logic [$clog2(DEPTH):0]          count_o
);
   localparam int PW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW:0]      wr_ptr;
   logic [PW:0]      rd_ptr;
   logic             push;
   logic             pop;

   assign count_o = wr_ptr - rd_ptr;
   assign in_ready_o = (count_o != DEPTH[PW:0]) || (wr_ptr[PW] == rd_ptr[PW]);
   assign out_valid_o = (wr_ptr != rd_ptr);
   assign out_data_o = mem[rd_ptr[PW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr[PW-1:0]] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   fifo_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
      count_o <= DEPTH) else $error("FIFO count above depth.");
endmodule

module dadc_chan #(
   parameter int WIDTH = 12,
   parameter int LAT   = 5
) (
   input  wire logic                clk_i,
   input  wire logic                rst_i,
   input  wire logic                sample_clock_i,
   input  wire logic [WIDTH-1:0]    sample_code_i,
   input  wire logic                sample_ovr_i,
   input  wire logic                power_select_i,
   input  wire logic                drive_enable_n_i,
   input  wire logic                twos_i,
   output dadc_pkg::dadc_word_t     result_o,
   output logic                     update_o,
   output logic                     clk_level_o,
   output dadc_pkg::dadc_state_t    state_o
);
   logic                 clk_s1;
   logic                 clk_s2;
   logic                 clk_s3;
   logic [WIDTH-1:0]     code_s1;
   logic [WIDTH-1:0]     code_s2;
   logic                 ovr_s1;
   logic                 ovr_s2;
   logic                 rise;
   logic                 converting;
   dadc_pkg::dadc_word_t pipe [LAT];
   dadc_pkg::dadc_word_t next_result;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_s1  <= 1'b0;
         clk_s2  <= 1'b0;
         clk_s3  <= 1'b0;
         code_s1 <= '0;
         code_s2 <= '0;
         ovr_s1  <= 1'b0;
         ovr_s2  <= 1'b0;
      end else begin
         clk_s1  <= sample_clock_i;
         clk_s2  <= clk_s1;
         clk_s3  <= clk_s2;
         code_s1 <= sample_code_i;
         code_s2 <= code_s1;
         ovr_s1  <= sample_ovr_i;
         ovr_s2  <= ovr_s1;
      end
   end

   assign rise = clk_s2 && !clk_s3;
   assign clk_level_o = clk_s3;
   assign converting = !power_select_i;

   always_comb begin
      case ({power_select_i, drive_enable_n_i})
         2'b00: state_o = dadc_pkg::DADC_NORMAL;
         2'b01: state_o = dadc_pkg::DADC_HIZ;
         2'b10: state_o = dadc_pkg::DADC_NAP;
         2'b11: state_o = dadc_pkg::DADC_SLEEP;
         default: state_o = dadc_pkg::DADC_SLEEP;
      endcase
   end

   always_comb begin
      next_result = pipe[LAT-1];
      next_result.code[WIDTH-1] = pipe[LAT-1].code[WIDTH-1] ^ twos_i;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < LAT; i++) begin
            pipe[i] <= '0;
         end
      end else if (rise && converting) begin
         pipe[0] <= '{ovr: ovr_s2, code: code_s2};
         for (int i = 1; i < LAT; i++) begin
            pipe[i] <= pipe[i-1];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         result_o <= '0;
         update_o <= 1'b0;
      end else begin
         update_o <= rise && converting;
         if (rise && converting) begin
            result_o <= next_result;
         end
      end
   end

   result_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !(rise && converting) |=> $stable(result_o)) else $error("Result changed without a sample edge.");
   nap_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
      power_select_i [*2] |-> $stable(result_o)) else $error("Result moved while powered down.");
   msb_format_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (rise && converting) |=> result_o.code[WIDTH-1] == ($past(pipe[LAT-1].code[WIDTH-1]) ^ $past(twos_i)))
      else $error("MSB format wrong.");
endmodule

module dadc_port #(
   parameter int WIDTH = dadc_pkg::CODE_WIDTH,
   parameter int DEPTH = dadc_pkg::FIFO_DEPTH
) (
   input  wire logic                                clk_i,
   input  wire logic                                rst_i,
   input  wire logic [dadc_pkg::ADDR_WIDTH-1:0]     avs_address_i,
   input  wire logic                                avs_read_i,
   input  wire logic                                avs_write_i,
   input  wire logic [31:0]                         avs_writedata_i,
   input  wire logic [3:0]                          avs_byteenable_i,
   output logic [31:0]                              avs_readdata_o,
   output logic                                     avs_waitrequest_o,
   input  wire logic                                chan_a_sample_clock_i,
   input  wire logic                                chan_b_sample_clock_i,
   input  wire logic [WIDTH-1:0]                    chan_a_code_i,
   input  wire logic                                chan_a_ovr_i,
   input  wire logic [WIDTH-1:0]                    chan_b_code_i,
   input  wire logic                                chan_b_ovr_i,
   output logic [WIDTH-1:0]                         bus_a_data_o,
   output logic                                     bus_a_data_oe_o,
   output logic [WIDTH-1:0]                         bus_b_data_o,
   output logic                                     bus_b_data_oe_o,
   output logic                                     range_exceeded_flag_o,
   output logic                                     data_ready_strobe_o,
   output logic                                     duty_stabilizer_on_o
);
   localparam int CW     = $clog2(DEPTH) + 1;
   localparam int CAP_HI = dadc_pkg::CAP_FLAG;

   logic [6:0]            ctrl;
   logic                  output_swap_select;
   logic                  chan_a_power_select;
   logic                  chan_b_power_select;
   logic                  chan_a_drive_enable_n;
   logic                  chan_b_drive_enable_n;
   logic [1:0]            format_mode;
   logic                  twos;
   logic                  ack;
   logic                  taken_rd;
   logic                  taken_wr;
   logic                  drop;
   logic                  fifo_in_ready;
   logic                  fifo_out_valid;
   logic                  fifo_pop;
   logic [CW-1:0]         fifo_count;
   dadc_pkg::dadc_pair_t  fifo_in;
   dadc_pkg::dadc_pair_t  fifo_out;
   dadc_pkg::dadc_word_t  res_a;
   dadc_pkg::dadc_word_t  res_b;
   logic                  upd_a;
   logic                  upd_b;
   logic                  b_level;
   dadc_pkg::dadc_state_t state_a;
   dadc_pkg::dadc_state_t state_b;
   logic [31:0]           next_readdata;

   assign output_swap_select = ctrl[dadc_pkg::CTRL_SWAP];
   assign chan_a_power_select = ctrl[dadc_pkg::CTRL_PWR_A];
   assign chan_b_power_select = ctrl[dadc_pkg::CTRL_PWR_B];
   assign chan_a_drive_enable_n = ctrl[dadc_pkg::CTRL_DEN_A];
   assign chan_b_drive_enable_n = ctrl[dadc_pkg::CTRL_DEN_B];
   assign format_mode = ctrl[dadc_pkg::CTRL_MODE +: 2];
   assign twos = format_mode[1];

   dadc_chan #(.WIDTH(WIDTH), .LAT(dadc_pkg::LATENCY)) u_chan_a (
      .clk_i            (clk_i),
      .rst_i            (rst_i),
      .sample_clock_i   (chan_a_sample_clock_i),
      .sample_code_i    (chan_a_code_i),
      .sample_ovr_i     (chan_a_ovr_i),
      .power_select_i   (chan_a_power_select),
      .drive_enable_n_i (chan_a_drive_enable_n),
      .twos_i           (twos),
      .result_o         (res_a),
      .update_o         (upd_a),
      .clk_level_o      (),
      .state_o          (state_a)
   );

   dadc_chan #(.WIDTH(WIDTH), .LAT(dadc_pkg::LATENCY)) u_chan_b (
      .clk_i            (clk_i),
      .rst_i            (rst_i),
      .sample_clock_i   (chan_b_sample_clock_i),
      .sample_code_i    (chan_b_code_i),
      .sample_ovr_i     (chan_b_ovr_i),
      .power_select_i   (chan_b_power_select),
      .drive_enable_n_i (chan_b_drive_enable_n),
      .twos_i           (twos),
      .result_o         (res_b),
      .update_o         (upd_b),
      .clk_level_o      (b_level),
      .state_o          (state_b)
   );

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_a_data_o <= '0;
         bus_b_data_o <= '0;
      end else if (output_swap_select) begin
         bus_a_data_o <= res_a.code;
         bus_b_data_o <= res_b.code;
      end else begin
         bus_a_data_o <= res_b.code;
         bus_b_data_o <= res_a.code;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_a_data_oe_o <= 1'b0;
         bus_b_data_oe_o <= 1'b0;
         range_exceeded_flag_o <= 1'b0;
         data_ready_strobe_o <= 1'b0;
         duty_stabilizer_on_o <= 1'b0;
      end else begin
         bus_a_data_oe_o <= (state_a == dadc_pkg::DADC_NORMAL);
         bus_b_data_oe_o <= (state_b == dadc_pkg::DADC_NORMAL);
         range_exceeded_flag_o <= res_a.ovr || res_b.ovr;
         data_ready_strobe_o <= b_level;
         duty_stabilizer_on_o <= format_mode[1] ^ format_mode[0];
      end
   end

   assign fifo_in = '{ovr: res_a.ovr || res_b.ovr, b: res_b.code, a: res_a.code};

   dadc_fifo #(.WIDTH($bits(dadc_pkg::dadc_pair_t)), .DEPTH(DEPTH)) u_fifo (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .in_valid_i  (upd_b),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (fifo_in),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_out),
      .count_o     (fifo_count)
   );

   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
   assign taken_rd = avs_read_i && ack;
   assign taken_wr = avs_write_i && ack;
   // Pops only what the finished read reported, so a pair that arrives during an empty read is kept.
   assign fifo_pop = taken_rd && (avs_address_i == dadc_pkg::ADDR_CAPTURE) && avs_readdata_o[dadc_pkg::CAP_VALID];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read_i || avs_write_i) && !ack;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= dadc_pkg::CTRL_RESET;
      end else if (taken_wr && avs_address_i == dadc_pkg::ADDR_CTRL && avs_byteenable_i[0]) begin
         ctrl <= avs_writedata_i[6:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         drop <= 1'b0;
      end else if (upd_b && !fifo_in_ready) begin
         drop <= 1'b1;
      end else if (taken_wr && avs_address_i == dadc_pkg::ADDR_STATUS && avs_byteenable_i[0]
                   && avs_writedata_i[dadc_pkg::ST_DROP]) begin
         drop <= 1'b0;
      end
   end

   always_comb begin
      next_readdata = '0;
      case (avs_address_i)
         dadc_pkg::ADDR_CTRL: next_readdata[6:0] = ctrl;
         dadc_pkg::ADDR_STATUS: begin
            next_readdata[dadc_pkg::ST_FLAG] = range_exceeded_flag_o;
            next_readdata[dadc_pkg::ST_STATE_A +: 2] = state_a;
            next_readdata[dadc_pkg::ST_STATE_B +: 2] = state_b;
            next_readdata[dadc_pkg::ST_STAB] = duty_stabilizer_on_o;
            next_readdata[dadc_pkg::ST_DROP] = drop;
            next_readdata[dadc_pkg::ST_COUNT +: CW] = fifo_count;
         end
         dadc_pkg::ADDR_CAPTURE: begin
            if (fifo_out_valid) begin
               next_readdata[CAP_HI:0] = fifo_out;
               next_readdata[dadc_pkg::CAP_VALID] = 1'b1;
            end
         end
         default: next_readdata = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         avs_readdata_o <= '0;
      end else if (avs_read_i && !ack) begin
         avs_readdata_o <= next_readdata;
      end
   end

   swap_direct_a: assert property (@(posedge clk_i) disable iff (rst_i)
      output_swap_select |=> bus_a_data_o == $past(res_a.code) && bus_b_data_o == $past(res_b.code))
      else $error("Direct bus routing wrong.");
   swap_cross_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !output_swap_select |=> bus_a_data_o == $past(res_b.code) && bus_b_data_o == $past(res_a.code))
      else $error("Crossed bus routing wrong.");
   drive_enable_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (chan_a_power_select || chan_a_drive_enable_n) |=> !bus_a_data_oe_o)
      else $error("Bus A driven while disabled.");
   drive_normal_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!chan_b_power_select && !chan_b_drive_enable_n) |=> bus_b_data_oe_o)
      else $error("Bus B not driven in normal mode.");
   range_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
      range_exceeded_flag_o == $past(res_a.ovr || res_b.ovr))
      else $error("Range flag does not follow results.");
   stab_mode_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (format_mode == dadc_pkg::MODE_TWO_THIRDS) [*2] |-> duty_stabilizer_on_o)
      else $error("Stabilizer off in mode two.");
   strobe_source_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $changed(data_ready_strobe_o) |-> $past(b_level) == data_ready_strobe_o)
      else $error("Strobe not from channel B clock.");
   bus_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("Bus answer not after one wait cycle.");
endmodule

// >>> hdl/dadc_pkg.sv
// Shared constants, register map and types of the dual converter output port.
package dadc_pkg;
   localparam int CODE_WIDTH = 12;
   localparam int LATENCY = 5;
   localparam int FIFO_DEPTH = 8;
   localparam int ADDR_WIDTH = 4;

   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_CAPTURE = 4'h8;

   localparam int CTRL_SWAP = 0;
   localparam int CTRL_PWR_A = 1;
   localparam int CTRL_PWR_B = 2;
   localparam int CTRL_DEN_A = 3;
   localparam int CTRL_DEN_B = 4;
   localparam int CTRL_MODE = 5;
   localparam logic [6:0] CTRL_RESET = 7'h19;

   localparam int ST_FLAG = 0;
   localparam int ST_STATE_A = 1;
   localparam int ST_STATE_B = 3;
   localparam int ST_STAB = 5;
   localparam int ST_DROP = 6;
   localparam int ST_COUNT = 8;

   localparam int CAP_B = 12;
   localparam int CAP_FLAG = 24;
   localparam int CAP_VALID = 31;

   localparam logic [1:0] MODE_GND = 2'h0;
   localparam logic [1:0] MODE_THIRD = 2'h1;
   localparam logic [1:0] MODE_TWO_THIRDS = 2'h2;
   localparam logic [1:0] MODE_FULL = 2'h3;

   typedef enum logic [1:0] {
      DADC_NORMAL = 2'b00,
      DADC_HIZ    = 2'b01,
      DADC_NAP    = 2'b10,
      DADC_SLEEP  = 2'b11
   } dadc_state_t;

   typedef struct packed {
      logic                  ovr;
      logic [CODE_WIDTH-1:0] code;
   } dadc_word_t;

   typedef struct packed {
      logic                  ovr;
      logic [CODE_WIDTH-1:0] b;
      logic [CODE_WIDTH-1:0] a;
   } dadc_pair_t;
endpackage

// >>> tb/dadc_capture_model.sv
// Capture logic model that latches both output buses on the falling data ready strobe.
`timescale 1ns/1ps
module dadc_capture_model (
   input  wire logic        strobe_i,
   input  wire logic [11:0] bus_a_data_i,
   input  wire logic        bus_a_oe_i,
   input  wire logic [11:0] bus_b_data_i,
   input  wire logic        bus_b_oe_i,
   output logic [11:0]      cap_a_o,
   output logic [11:0]      cap_b_o,
   output logic [31:0]      cap_count_o
);
   logic [11:0] last_a;
   logic [11:0] last_b;
   logic [11:0] wire_a;
   logic [11:0] wire_b;
   initial begin
      last_a = 12'h000;
      last_b = 12'h000;
      cap_a_o = 12'h000;
      cap_b_o = 12'h000;
      cap_count_o = 0;
   end
   // A released bus shows the inverse of its last driven value.
   always @(bus_a_oe_i or bus_a_data_i) if (bus_a_oe_i) last_a = bus_a_data_i;
   always @(bus_b_oe_i or bus_b_data_i) if (bus_b_oe_i) last_b = bus_b_data_i;
   assign wire_a = bus_a_oe_i ? bus_a_data_i : ~last_a;
   assign wire_b = bus_b_oe_i ? bus_b_data_i : ~last_b;
   always @(negedge strobe_i) begin
      cap_a_o <= wire_a;
      cap_b_o <= wire_b;
      cap_count_o <= cap_count_o + 1;
   end
endmodule

// >>> tb/dadc_port_tb.sv
// Self-checking bench of the dual converter output port.
`timescale 1ns/1ps
module dadc_port_tb;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [3:0]  avs_address_i = 4'h0;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic        sclk_a = 1'b0;
   logic        sclk_b = 1'b0;
   logic        run_a = 1'b1;
   logic        run_b = 1'b1;
   logic [11:0] code_a = 12'h000;
   logic [11:0] code_b = 12'h000;
   logic        ovr_a = 1'b0;
   logic        ovr_b = 1'b0;
   logic [11:0] bus_a_data_o;
   logic [11:0] bus_b_data_o;
   logic        bus_a_data_oe_o;
   logic        bus_b_data_oe_o;
   logic        range_exceeded_flag_o;
   logic        data_ready_strobe_o;
   logic        duty_stabilizer_on_o;
   logic [11:0] cap_a;
   logic [11:0] cap_b;
   logic [31:0] cap_count;
   logic [2:0]  div = 3'h0;
   logic [31:0] edge_cnt = 0;
   int          miscompares = 0;
   int          checks_done = 0;

   always #12.5 clk_i = ~clk_i;

   dadc_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .chan_a_sample_clock_i(sclk_a), .chan_b_sample_clock_i(sclk_b), .chan_a_code_i(code_a),
      .chan_a_ovr_i(ovr_a), .chan_b_code_i(code_b), .chan_b_ovr_i(ovr_b), .bus_a_data_o(bus_a_data_o),
      .bus_a_data_oe_o(bus_a_data_oe_o), .bus_b_data_o(bus_b_data_o), .bus_b_data_oe_o(bus_b_data_oe_o),
      .range_exceeded_flag_o(range_exceeded_flag_o), .data_ready_strobe_o(data_ready_strobe_o),
      .duty_stabilizer_on_o(duty_stabilizer_on_o));

   dadc_capture_model i_cap (.strobe_i(data_ready_strobe_o), .bus_a_data_i(bus_a_data_o),
      .bus_a_oe_i(bus_a_data_oe_o), .bus_b_data_i(bus_b_data_o), .bus_b_oe_i(bus_b_data_oe_o),
      .cap_a_o(cap_a), .cap_b_o(cap_b), .cap_count_o(cap_count));

   function automatic logic [11:0] fa(input logic [31:0] n);
      return 12'h123 + n[11:0] * 12'h035;
   endfunction

   // Both sample clocks come from one divider, 200 ns period, codes change mid-period.
   always @(posedge clk_i) begin
      div <= div + 3'h1;
      if (div == 3'h7) begin
         sclk_a <= run_a;
         sclk_b <= run_b;
         edge_cnt <= edge_cnt + 1;
      end
      if (div == 3'h3) begin
         sclk_a <= 1'b0;
         sclk_b <= 1'b0;
         code_a <= fa(edge_cnt);
         code_b <= fa(edge_cnt) ^ 12'hA5A;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= wr;
      avs_read_i <= !wr;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      q = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask

   task automatic periods(input int n);
      repeat (n * 8) @(posedge clk_i);
   endtask

   task automatic chk_bus(input logic sw, input logic inv);
      logic [11:0] ea;
      logic [11:0] eb;
      do @(posedge clk_i); while (div != 3'h5);
      ea = fa(edge_cnt - 6) ^ {inv, 11'h000};
      eb = ea ^ 12'hA5A;
      chk(bus_a_data_o, sw ? ea : eb);
      chk(bus_b_data_o, sw ? eb : ea);
   endtask

   task automatic t_reset_vals();
      logic [31:0] q;
      chk({bus_a_data_oe_o, bus_b_data_oe_o, duty_stabilizer_on_o}, 3'h0);
      av(1'b0, dadc_pkg::ADDR_CTRL, 32'h0, q);
      chk(q, {25'h0, dadc_pkg::CTRL_RESET});
      av(1'b0, 4'hC, 32'h0, q);
      chk(q, 32'h0);
      $display("reset values done");
   endtask

   task automatic t_swap();
      logic [31:0] q;
      int c;
      av(1'b1, dadc_pkg::ADDR_CTRL, 32'h01, q);
      periods(6);
      chk({bus_a_data_oe_o, bus_b_data_oe_o}, 2'h3);
      chk_bus(1'b1, 1'b0);
      av(1'b1, dadc_pkg::ADDR_CTRL, 32'h00, q);
      periods(1);
      chk_bus(1'b0, 1'b0);
      c = cap_count;
      repeat (20) @(posedge clk_i);
      chk(cap_count != c, 1'b1);
      chk({cap_a, cap_b}, {bus_a_data_o, bus_b_data_o});
      $display("swap and latency done");
   endtask

   task automatic t_modes();
      logic [31:0] q;
      for (int m = 0; m < 4; m++) begin
         av(1'b1, dadc_pkg::ADDR_CTRL, 32'h01 | (m << 5), q);
         periods(6);
         chk(duty_stabilizer_on_o, (m == 1 || m == 2));
         chk_bus(1'b1, m >= 2);
      end
      $display("modes done");
   endtask

   task automatic t_power();
      logic [31:0] q;
      for (int i = 0; i < 4; i++) begin
         av(1'b1, dadc_pkg::ADDR_CTRL, 32'h01 | (i[1] << 1) | (i[0] << 3), q);
         repeat (4) @(posedge clk_i);
         av(1'b0, dadc_pkg::ADDR_STATUS, 32'h0, q);
         chk(q[2:1], i[1:0]);
         chk({bus_a_data_oe_o, bus_b_data_oe_o}, {i == 0, 1'b1});
      end
      av(1'b1, dadc_pkg::ADDR_CTRL, 32'h01, q);
      periods(6);
      chk_bus(1'b1, 1'b0);
      $display("power modes done");
   endtask

   task automatic t_flag();
      for (int ch = 0; ch < 2; ch++) begin
         do @(posedge clk_i); while (div != 3'h3);
         if (ch == 0) ovr_a <= 1'b1;
         else ovr_b <= 1'b1;
         periods(3);
         chk(range_exceeded_flag_o, 1'b0);
         periods(4);
         chk(range_exceeded_flag_o, 1'b1);
         ovr_a <= 1'b0;
         ovr_b <= 1'b0;
         periods(7);
         chk(range_exceeded_flag_o, 1'b0);
      end
      $display("range flag done");
   endtask

   task automatic t_fifo();
      logic [31:0] q;
      int n;
      n = 0;
      // Flush the pairs captured right after reset, then refill with pairs of steady clocks.
      do begin
         av(1'b0, dadc_pkg::ADDR_CAPTURE, 32'h0, q);
         n++;
      end while (q[31] && n < 40);
      periods(10);
      run_b <= 1'b0;
      periods(2);
      av(1'b0, dadc_pkg::ADDR_STATUS, 32'h0, q);
      chk({q[11:8], q[6]}, {4'h8, 1'b1});
      n = 0;
      do begin
         av(1'b0, dadc_pkg::ADDR_CAPTURE, 32'h0, q);
         if (q[31]) begin
            n++;
            chk(q[23:12] ^ q[11:0], 12'hA5A);
         end
      end while (q[31] && n < 20);
      chk(n, 8);
      chk(q, 32'h0);
      av(1'b1, dadc_pkg::ADDR_STATUS, 32'h40, q);
      av(1'b0, dadc_pkg::ADDR_STATUS, 32'h0, q);
      chk({q[11:8], q[6]}, 5'h00);
      run_b <= 1'b1;
      periods(10);
      av(1'b0, dadc_pkg::ADDR_STATUS, 32'h0, q);
      chk({q[11:8], q[6]}, {4'h8, 1'b1});
      $display("fifo done");
   endtask

   task automatic t_strobe();
      int c;
      run_a <= 1'b0;
      c = cap_count;
      periods(5);
      chk(cap_count != c, 1'b1);
      run_a <= 1'b1;
      run_b <= 1'b0;
      periods(2);
      c = cap_count;
      periods(5);
      chk(cap_count, c);
      run_b <= 1'b1;
      $display("strobe source done");
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset_vals();
      t_swap();
      t_modes();
      t_power();
      t_flag();
      t_fifo();
      t_strobe();
      conclude();
   end

   initial begin
      #(25.0 * 12000);
      miscompares++;
      conclude();
   end
endmodule
